// file: design/ipic_regs.svh
// Purpose: Register offsets, field positions, reset values and timing counts.
// Assumes: Classic Wishbone with 32-bit data; one aligned word per register.
// Notes:   Definitions only.
`ifndef IPIC_REGS_SVH
`define IPIC_REGS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define IPIC_ADDR_W          6
`define IPIC_OFS_PRIO        6'h00
`define IPIC_OFS_PWR         6'h04
`define IPIC_OFS_STATE       6'h08
`define IPIC_OFS_ENABLE      6'h0c
`define IPIC_OFS_IRQ_STAT    6'h10
`define IPIC_OFS_IRQ_MASK    6'h14
`define IPIC_OFS_MCD_CTRL    6'h18

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define IPIC_PRIO_RST        8'h00
`define IPIC_EN_RST          8'h00
`define IPIC_PWR_IDLE_BIT    0
`define IPIC_PWR_STOP_BIT    1
`define IPIC_EV_IDLE_BIT     0
`define IPIC_EV_STOP_BIT     1
`define IPIC_EV_WAKE_BIT     2
`define IPIC_EV_RESET_BIT    3
`define IPIC_EV_W            4
`define IPIC_RESET_VECTOR    16'h0000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define IPIC_CLK_MHZ         125
`define IPIC_MCD_TIMEOUT_US  100
`define IPIC_MCD_CYCLES      (`IPIC_MCD_TIMEOUT_US * `IPIC_CLK_MHZ)

`endif

// file: design/ipic_pkg.sv
// Purpose: Types shared by the priority and idle control block.
// Assumes: Constants live in ipic_regs.svh.
// Notes:   None.
package ipic_pkg;

   // -------------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      PWR_RUN,
      PWR_IDLE,
      PWR_STOP
   } ipic_pwr_e;

   typedef struct packed {
      logic [7:0]  prio;
      logic [7:0]  enable;
      logic [3:0]  stat;
      logic [3:0]  mask;
      logic        mcd_en;
      ipic_pwr_e   mode;
      logic        ack;
      logic [31:0] rdata;
      logic        cpu_run;
      logic        svc_valid;
      logic        svc_high;
      logic [2:0]  svc_id;
      logic        fetch_reset;
      logic [15:0] resume_pc;
      logic        resume_pending;
   } ipic_state_s;

endpackage

// file: design/ipic_core.sv
// Purpose: Interrupt priority register and idle/stop power control.
// Assumes: Single clock at 125 MHz; synchronous active-high reset.
// Notes:   Wake, reset and watchdog requests come from pins and are synchronised.
//
// Functional notes
// - Eight-bit priority register, reset zero, one bit per source, high or low.
// - Two software low-power states exist: idle and stop.
// - Idle halts the processor while clocks and peripherals keep running.
// - Stop halts the clock; interrupts and timers inactive except missing-clock detector.
// - Writing power bit 0 enters idle right after the writing instruction.
// - Registers and memory keep their contents while idle.
// - Only an enabled interrupt, the reset pin or a watchdog reset ends idle.
// - Enabled-interrupt wake clears idle bit, resumes processor, services interrupt.
// - After return-from-interrupt execution continues after the idle-setting instruction.
// - Reset ending idle runs normal reset and fetches from address zero.
// - Enabled watchdog keeps counting in idle and its reset ends idle.
// - After oscillator off, the device restarts only through reset.
// - Writing power bit 1 enters stop once the writing instruction completes.
// - Stop ends only by reset, then runs from address zero.
// - Enabled missing-clock detector resets out of stop after 100 microseconds.
//
// Chosen here: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`include "ipic_regs.svh"

module ipic_core
   import ipic_pkg::*;
#(
   parameter int MCD_CYCLES = `IPIC_MCD_CYCLES
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [5:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic [7:0]  irq_req_i,
   input  wire logic        reset_pin_i,
   input  wire logic        wdt_reset_i,
   input  wire logic        instr_done_i,
   input  wire logic [15:0] next_pc_i,
   input  wire logic        return_from_interrupt_i,
   output logic             cpu_run_o,
   output logic             clk_gate_o,
   output logic             periph_run_o,
   output logic             svc_valid_o,
   output logic             svc_high_o,
   output logic      [2:0]  svc_id_o,
   output logic             fetch_reset_o,
   output logic      [15:0] resume_pc_o,
   output logic      [15:0] fetch_addr_o,
   output logic             irq_o
);

   // -------------------------------------------------------------------------
   // Input synchronisers
   // -------------------------------------------------------------------------
   logic [9:0] sync1_r;
   logic [9:0] sync2_r;
   logic [7:0] req_s;
   logic       rst_pin_s;
   logic       wdt_s;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= {wdt_reset_i, reset_pin_i, irq_req_i};
         sync2_r <= sync1_r;
      end
   end

   assign req_s     = sync2_r[7:0];
   assign rst_pin_s = sync2_r[8];
   assign wdt_s     = sync2_r[9];

   // -------------------------------------------------------------------------
   // State and missing-clock counter
   // -------------------------------------------------------------------------
   ipic_state_s st_r;
   ipic_state_s st_nxt;
   logic [31:0] mcd_cnt_r;
   logic        mcd_fire;

   always_ff @(posedge clk_i) begin
      if (rst_i || st_r.mode != PWR_STOP || !st_r.mcd_en) begin
         mcd_cnt_r <= '0;
      end else if (!mcd_fire) begin
         mcd_cnt_r <= mcd_cnt_r + 32'h1;
      end
   end

   assign mcd_fire = (mcd_cnt_r >= 32'(MCD_CYCLES - 1));

   // -------------------------------------------------------------------------
   // Priority resolve
   // -------------------------------------------------------------------------
   logic [7:0] live;
   logic [7:0] hi_req;
   logic [7:0] lo_req;
   logic [2:0] hi_id;
   logic [2:0] lo_id;
   logic       hi_any;
   logic       lo_any;

   assign live   = req_s & st_r.enable;
   assign hi_req = live & st_r.prio;
   assign lo_req = live & ~st_r.prio;
   assign hi_any = |hi_req;
   assign lo_any = |lo_req;

   always_comb begin
      hi_id = 3'h0;
      lo_id = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (hi_req[i]) begin
            hi_id = 3'(i);
         end
         if (lo_req[i]) begin
            lo_id = 3'(i);
         end
      end
   end

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   logic       wr;
   logic       rd;
   logic       any_reset;
   logic [3:0] ev;
   logic [7:0] wbyte;

   assign wr        = cyc_i && stb_i && we_i && !st_r.ack;
   assign rd        = cyc_i && stb_i && !we_i && !st_r.ack;
   assign wbyte     = sel_i[0] ? dat_i[7:0] : 8'h00;
   assign any_reset = rst_pin_s || wdt_s || mcd_fire;

   always_comb begin
      st_nxt           = st_r;
      ev               = '0;
      st_nxt.ack       = cyc_i && stb_i && !st_r.ack;
      st_nxt.svc_valid = 1'b0;
      st_nxt.fetch_reset = 1'b0;
      st_nxt.rdata     = '0;
      if (rd) begin
         case (adr_i)
            `IPIC_OFS_PRIO:     st_nxt.rdata = {24'h0, st_r.prio};
            `IPIC_OFS_PWR:      st_nxt.rdata = 32'h0;
            `IPIC_OFS_STATE:    st_nxt.rdata = {30'h0, st_r.mode};
            `IPIC_OFS_ENABLE:   st_nxt.rdata = {24'h0, st_r.enable};
            `IPIC_OFS_IRQ_STAT: st_nxt.rdata = {28'h0, st_r.stat};
            `IPIC_OFS_IRQ_MASK: st_nxt.rdata = {28'h0, st_r.mask};
            `IPIC_OFS_MCD_CTRL: st_nxt.rdata = {31'h0, st_r.mcd_en};
            default:            st_nxt.rdata = 32'h0;
         endcase
      end
      if (wr && sel_i[0]) begin
         case (adr_i)
            `IPIC_OFS_PRIO:     st_nxt.prio   = wbyte;
            `IPIC_OFS_ENABLE:   st_nxt.enable = wbyte;
            `IPIC_OFS_IRQ_MASK: st_nxt.mask   = wbyte[3:0];
            `IPIC_OFS_MCD_CTRL: st_nxt.mcd_en = wbyte[0];
            `IPIC_OFS_IRQ_STAT: st_nxt.stat   = st_r.stat & ~wbyte[3:0];
            default:            st_nxt.mode   = st_r.mode;
         endcase
      end
      case (st_r.mode)
         PWR_RUN: begin
            if (wr && sel_i[0] && adr_i == `IPIC_OFS_PWR) begin
               if (wbyte[`IPIC_PWR_STOP_BIT]) begin
                  st_nxt.mode = PWR_STOP;
                  ev[`IPIC_EV_STOP_BIT] = 1'b1;
               end else if (wbyte[`IPIC_PWR_IDLE_BIT]) begin
                  st_nxt.mode = PWR_IDLE;
                  st_nxt.resume_pc = next_pc_i;
                  ev[`IPIC_EV_IDLE_BIT] = 1'b1;
               end
            end
            if (hi_any) begin
               st_nxt.svc_valid = 1'b1;
               st_nxt.svc_high  = 1'b1;
               st_nxt.svc_id    = hi_id;
            end else if (lo_any) begin
               st_nxt.svc_valid = 1'b1;
               st_nxt.svc_high  = 1'b0;
               st_nxt.svc_id    = lo_id;
            end
            if (return_from_interrupt_i && st_r.resume_pending) begin
               st_nxt.resume_pending = 1'b0;
            end
         end
         PWR_IDLE: begin
            if (any_reset) begin
               st_nxt.mode = PWR_RUN;
               ev[`IPIC_EV_RESET_BIT] = 1'b1;
            end else if (hi_any || lo_any) begin
               st_nxt.mode = PWR_RUN;
               st_nxt.resume_pending = 1'b1;
               ev[`IPIC_EV_WAKE_BIT] = 1'b1;
            end
         end
         PWR_STOP: begin
            if (any_reset) begin
               st_nxt.mode = PWR_RUN;
               ev[`IPIC_EV_RESET_BIT] = 1'b1;
            end
         end
         default: st_nxt.mode = PWR_RUN;
      endcase
      // No grant once the core halts.
      // A grant in the entry cycle would reach a core that is already stopped.
      if (st_nxt.mode != PWR_RUN) begin
         st_nxt.svc_valid = 1'b0;
      end
      if (ev[`IPIC_EV_RESET_BIT]) begin
         st_nxt.fetch_reset    = 1'b1;
         st_nxt.resume_pending = 1'b0;
      end
      // Processor stops in idle and stop.
      st_nxt.cpu_run = (st_nxt.mode == PWR_RUN);
      // Set wins over a same-cycle clear.
      st_nxt.stat = st_nxt.stat | ev;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r        <= '0;
         st_r.prio   <= `IPIC_PRIO_RST;
         st_r.enable <= `IPIC_EN_RST;
         st_r.mode   <= PWR_RUN;
         st_r.cpu_run <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   assign dat_o        = st_r.rdata;
   assign ack_o        = st_r.ack;
   assign cpu_run_o    = st_r.cpu_run;
   // Clock and peripherals stop only in stop.
   assign clk_gate_o   = (st_r.mode == PWR_STOP);
   assign periph_run_o = (st_r.mode != PWR_STOP);
   assign svc_valid_o  = st_r.svc_valid;
   assign svc_high_o   = st_r.svc_high;
   assign svc_id_o     = st_r.svc_id;
   assign fetch_reset_o = st_r.fetch_reset;
   assign resume_pc_o  = st_r.resume_pc;
   assign fetch_addr_o = st_r.fetch_reset ? `IPIC_RESET_VECTOR : st_r.resume_pc;
   assign irq_o        = |(st_r.stat & st_r.mask);

endmodule // ipic_core

// file: dv/ipic_core_props.sv
// Purpose: Port-level checks of ipic_core.
// Assumes: Bound to every ipic_core instance.
// Notes:   Bus timing follows the hand-over contract.
`timescale 1ns/1ps
`include "ipic_regs.svh"
module ipic_core_props
   import ipic_pkg::*;
#(
   parameter int MCD_CYCLES = 20
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [5:0]  adr_i,
   input wire logic [3:0]  sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        cpu_run_o,
   input wire logic        clk_gate_o,
   input wire logic        periph_run_o,
   input wire logic        svc_valid_o,
   input wire logic        fetch_reset_o,
   input wire logic [15:0] resume_pc_o,
   input wire logic [15:0] fetch_addr_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ----------------------------------------
   // Sequences and properties
   // ----------------------------------------
   sequence s_take;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_pwr_wr;
      s_take ##0 (we_i && sel_i[0] && adr_i == `IPIC_OFS_PWR);
   endsequence
   property p_ack; s_take |=> ack_o ##1 !ack_o; endproperty
   property p_rd0; !ack_o |-> dat_o == 32'h0; endproperty
   property p_idle; s_pwr_wr ##0 dat_i[1:0] == 2'h1 |-> ##[1:3] !cpu_run_o; endproperty
   property p_stop; s_pwr_wr ##0 dat_i[1] |-> ##[1:3] clk_gate_o; endproperty
   property p_dark; clk_gate_o |-> !cpu_run_o && !periph_run_o && !svc_valid_o; endproperty
   property p_live; !clk_gate_o |-> periph_run_o; endproperty
   property p_hold; !cpu_run_o && !$past(cpu_run_o) |-> !svc_valid_o; endproperty
   property p_vec; fetch_reset_o |-> fetch_addr_o == `IPIC_RESET_VECTOR ##1 !fetch_reset_o;
   endproperty
   property p_pc; !fetch_reset_o |-> fetch_addr_o == resume_pc_o; endproperty
   property p_wake; $fell(clk_gate_o) |-> ##[0:2] fetch_reset_o; endproperty
   a_ack: assert property (p_ack) else $error("ack not a single pulse");
   a_rd0: assert property (p_rd0) else $error("read data outside ack");
   a_idle: assert property (p_idle) else $error("idle not entered"); // idle entry
   a_stop: assert property (p_stop) else $error("stop not entered"); // stop entry
   a_dark: assert property (p_dark) else $error("activity in stop"); // stop quiet
   a_live: assert property (p_live) else $error("peripherals halted"); // idle live
   a_hold: assert property (p_hold) else $error("service while halted"); // no service
   a_vec: assert property (p_vec) else $error("reset fetch not zero"); // reset vector
   a_pc: assert property (p_pc) else $error("fetch not resume pc"); // resume point
   a_wake: assert property (p_wake) else $error("stop left without reset"); // reset exit
endmodule // ipic_core_props
bind ipic_core ipic_core_props #(.MCD_CYCLES(MCD_CYCLES)) i_ipic_core_props (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
   .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .cpu_run_o(cpu_run_o),
   .clk_gate_o(clk_gate_o), .periph_run_o(periph_run_o), .svc_valid_o(svc_valid_o),
   .fetch_reset_o(fetch_reset_o), .resume_pc_o(resume_pc_o), .fetch_addr_o(fetch_addr_o)
);

// file: dv/ipic_src_model.sv
// Purpose: Interrupt sources and core return path.
// Assumes: Requests are levels held until serviced.
// Notes:   Disabled requests stay pending, as real sources do.
`timescale 1ns/1ps
module ipic_src_model
   import ipic_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [7:0] raise_i,
   input  wire logic       svc_valid_i,
   input  wire logic [2:0] svc_id_i,
   output logic      [7:0] irq_req_o,
   output logic            return_from_interrupt_o
);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_req_o <= 8'h00;
         return_from_interrupt_o    <= 1'b0;
      end else begin
         // Service drops the level; return follows only the first grant.
         irq_req_o <= (irq_req_o | raise_i) & ~({7'h0, svc_valid_i} << svc_id_i);
         return_from_interrupt_o    <= svc_valid_i && irq_req_o[svc_id_i];
      end
   end
endmodule // ipic_src_model

// file: dv/irq_priority_and_idle_control_tb_top.sv
// Purpose: Self-checking bench of ipic_core.
// Assumes: Short missing-clock count of 20 cycles.
// Notes:   wait_on waits are bounded; the timer ends a hang on the ack wait in wb.
`timescale 1ns/1ps
`include "ipic_regs.svh"
module irq_priority_and_idle_control_tb_top
   import ipic_pkg::*;
;
   localparam logic [5:0] A_PRI = `IPIC_OFS_PRIO, A_PWR = `IPIC_OFS_PWR;
   localparam logic [5:0] A_ST = `IPIC_OFS_STATE, A_EN = `IPIC_OFS_ENABLE;
   localparam logic [5:0] A_EV = `IPIC_OFS_IRQ_STAT, A_MSK = `IPIC_OFS_IRQ_MASK;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic        rpin = 1'b0, wdt = 1'b0;
   logic        ack, run, gate, prun, sv, sh, frst, irq, return_from_interrupt;
   logic [2:0]  sid;
   logic [3:0]  sel = 4'hf;
   logic [5:0]  adr = 6'h00;
   logic [7:0]  raise = 8'h00, req, m_pri = 8'h00, m_en, rnd = 8'h2f;
   logic [15:0] npc = 16'h0000, rpc, fad;
   logic [31:0] wd = 32'h0, rdat, q;
   int          fails = 0, tests_run = 0, cyc_n = 0;
   always #4 clk_i = ~clk_i;
   ipic_core #(.MCD_CYCLES(20)) i_ipic_core (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(wd), .dat_o(rdat), .ack_o(ack), .irq_req_i(req),
      .reset_pin_i(rpin), .wdt_reset_i(wdt), .instr_done_i(1'b0), .next_pc_i(npc),
      .return_from_interrupt_i(return_from_interrupt), .cpu_run_o(run), .clk_gate_o(gate), .periph_run_o(prun),
      .svc_valid_o(sv), .svc_high_o(sh), .svc_id_o(sid), .fetch_reset_o(frst),
      .resume_pc_o(rpc), .fetch_addr_o(fad), .irq_o(irq));
   ipic_src_model i_ipic_src_model (.clk_i(clk_i), .rst_i(rst_i), .raise_i(raise),
      .svc_valid_i(sv), .svc_id_i(sid), .irq_req_o(req), .return_from_interrupt_o(return_from_interrupt));
   // ----------------------------------------
   // Model and tasks
   // ----------------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // High level first, then lowest index, so a mix of levels is the hard case.
   function automatic logic [31:0] best(input logic [7:0] p, input logic [7:0] r);
      for (int h = 1; h >= 0; h--)
         for (int i = 0; i < 8; i++)
            if (r[i] && p[i] == h) return h * 8 + i;
      return 32'hff;
   endfunction
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 20000) begin
         fails++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      chk({31'h0, g}, {31'h0, e});
   endtask
   task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      wd  <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic pulse(input logic [7:0] r);
      raise <= r;
      @(posedge clk_i);
      raise <= 8'h00;
   endtask
   task automatic wait_on(input int s);
      for (int n = 0; n < 200; n++) begin
         @(posedge clk_i);
         if ((s == 0 && sv === 1'b1) || (s == 1 && run === 1'b1) || (s == 2 && frst === 1'b1)
             || (s == 3 && req === 8'h00)) return;
      end
      fails++;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(A_PRI, 32'h0);
      rd(A_ST, 32'h0);
      rd(6'h3c, 32'h0);
      m_en = 8'hff;
      wb(1'b1, A_EN, {24'h0, m_en});
      for (int k = 0; k < 6; k++) begin
         rnd = lfsr(rnd);
         m_pri = rnd;
         wb(1'b1, A_PRI, {24'h0, m_pri});
         rd(A_PRI, {24'h0, m_pri});
         rnd = lfsr(rnd);
         pulse(rnd);
         wait_on(0);
         chk({28'h0, sh, sid}, best(m_pri, rnd & m_en));
         wait_on(3);
         repeat (4) @(posedge clk_i);
      end
      sel <= 4'h0;
      wb(1'b1, A_PRI, ~{24'h0, m_pri});
      sel <= 4'hf;
      rd(A_PRI, {24'h0, m_pri});
      $display("test priority done");
      m_en = 8'h01;
      wb(1'b1, A_EN, {24'h0, m_en});
      wb(1'b1, A_MSK, 32'hf);
      npc <= {rnd, 8'h5a};
      wb(1'b1, A_PWR, 32'h1);
      rd(A_ST, 32'h1);
      chk1(prun, 1'b1);
      pulse(8'h08);
      repeat (10) @(posedge clk_i);
      chk1(run, 1'b0);
      pulse(8'h01);
      wait_on(1);
      rd(A_ST, 32'h0);
      chk({16'h0, rpc}, {16'h0, npc});
      rd(A_PRI, {24'h0, m_pri});
      rd(A_EV, 32'h5);
      chk1(irq, 1'b1);
      wb(1'b1, A_MSK, 32'h0);
      repeat (2) @(posedge clk_i);
      chk1(irq, 1'b0);
      wb(1'b1, A_EV, 32'hf);
      rd(A_EV, 32'h0);
      $display("test idle done");
      wb(1'b1, A_PWR, 32'h1);
      wdt <= 1'b1;
      wait_on(2);
      wdt <= 1'b0;
      chk({16'h0, fad}, 32'h0);
      wb(1'b1, `IPIC_OFS_MCD_CTRL, 32'h0);
      wb(1'b1, A_PWR, 32'h2);
      rd(A_ST, 32'h2);
      chk1(prun, 1'b0);
      pulse(8'h01);
      repeat (30) @(posedge clk_i);
      chk1(gate, 1'b1);
      rpin <= 1'b1;
      wait_on(2);
      rpin <= 1'b0;
      chk({16'h0, fad}, 32'h0);
      wb(1'b1, `IPIC_OFS_MCD_CTRL, 32'h1);
      wb(1'b1, A_PWR, 32'h3);
      repeat (15) @(posedge clk_i);
      chk1(gate, 1'b1);
      wait_on(2);
      chk({16'h0, fad}, 32'h0);
      $display("test stop done");
      tally_and_finish();
   end
endmodule // irq_priority_and_idle_control_tb_top
